// [inc/aro_pkg.sv]
// shared constants for the augmented read overlay block
package aro_pkg;
	// apb byte addresses of the overlay registers
	localparam logic [7:0] ARO_OFS_ENABLE = 8'h00;
	localparam logic [7:0] ARO_OFS_CONFIG = 8'h04;
	localparam logic [7:0] ARO_OFS_SEP = 8'h08;
	localparam logic [7:0] ARO_OFS_CUST_LO = 8'h0c;
	localparam logic [7:0] ARO_OFS_CUST_HI = 8'h10;
	localparam logic [7:0] ARO_OFS_LOCK = 8'h14;
	localparam logic [7:0] ARO_OFS_BOOT = 8'h18;
	localparam logic [7:0] ARO_OFS_RANGE = 8'h1c;
	// overlay_config field positions
	localparam int ARO_BIT_ID_EN = 0;
	localparam int ARO_BIT_CUS_EN = 1;
	localparam int ARO_BIT_TAP_EN = 2;
	localparam int ARO_BIT_TD_EN = 4;
	localparam int ARO_BIT_SEP_EN = 5;
	localparam int ARO_BYTE_LSB = 6;
	localparam int ARO_BLOCK_LSB = 8;
	// reset (factory) values
	localparam logic ARO_RST_ENABLE = 1'b0;
	localparam logic [15:0] ARO_RST_CONFIG = 16'h0020;
	localparam logic [7:0] ARO_RST_SEP = 8'h78;
	localparam logic [31:0] ARO_RST_CUSTOM = 32'h2e2e2e2e;
	// field sizes in bytes
	localparam int ARO_ID_BYTES = 16;
	localparam int ARO_CUS_BYTES = 8;
	localparam int ARO_TAP_BYTES = 3;
	localparam int ARO_TD_BYTES = 3;
	localparam int ARO_BLOCK_BYTES = 4;
	// largest buffer: all fields plus three separators
	localparam int ARO_BUF_MAX = 33;
	// last user block of the memory
	localparam logic [7:0] ARO_LAST_BLOCK = 8'h4f;
endpackage

// [design/aro_overlay.sv]
// augmented read overlay: register file, boot latch and read-data substitution
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module aro_overlay #(
	parameter logic [7:0] LAST_BLOCK = aro_pkg::ARO_LAST_BLOCK
) (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// boot pulse from the rf front end, same clock
	input wire logic rf_boot,
	// live source values
	input wire logic [127:0] identifier_string,
	input wire logic [23:0] unique_tap_code,
	input wire logic [23:0] tamper_status,
	// block read request and user memory data for that block
	input wire logic rd_req,
	input wire logic [7:0] rd_block,
	input wire logic [31:0] um_rd_data,
	input wire logic [7:0] um_block_security_status,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic [7:0] rd_block_security_status,
	// single block write request towards user memory
	input wire logic wr_req,
	input wire logic [7:0] wr_block,
	input wire logic [31:0] wr_data,
	output logic mem_wr_en,
	output logic [7:0] mem_wr_block,
	output logic [31:0] mem_wr_data
);
	import aro_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register storage
	logic overlay_enable; // software enable, sampled at boot
	logic [15:0] overlay_config; // field enables and start position
	logic [7:0] separator_char; // separator byte
	logic [31:0] custom_string_low; // first four custom characters
	logic [31:0] custom_string_high; // last four custom characters
	logic overlay_lock; // once set, settings frozen
	// values caught at the most recent rf boot
	logic boot_enable;
	logic [15:0] boot_config;

	// apb decode helpers
	logic apb_wr; // write access phase
	logic apb_rd; // read access phase
	logic addr_ok; // address is mapped
	logic lock_hit; // locked register addressed, read or write
	logic next_lock;

	assign pready = 1'b1; // every access ends in one access cycle
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;

	// address decode, unmapped offsets answer with an error
	always_comb begin
		case (paddr)
			ARO_OFS_ENABLE, ARO_OFS_CONFIG, ARO_OFS_SEP, ARO_OFS_CUST_LO,
			ARO_OFS_CUST_HI, ARO_OFS_LOCK, ARO_OFS_BOOT, ARO_OFS_RANGE: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// locked registers refuse writes; boot/range readback is read only
	always_comb begin
		lock_hit = 1'b0;
		if (overlay_lock && paddr != ARO_OFS_LOCK && paddr != ARO_OFS_BOOT
				&& paddr != ARO_OFS_RANGE) begin
			lock_hit = 1'b1;
		end
	end
	assign pslverr = psel & penable & (~addr_ok | (pwrite & addr_ok & lock_hit));

	////////////////////////////////////////////////////////////////////////
	// software-written registers
	// enable bit, factory value zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overlay_enable <= ARO_RST_ENABLE;
		end else if (apb_wr && paddr == ARO_OFS_ENABLE && !overlay_lock) begin
			overlay_enable <= pwdata[0];
		end
	end

	// configuration: only the separator enable at factory delivery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overlay_config <= ARO_RST_CONFIG;
		end else if (apb_wr && paddr == ARO_OFS_CONFIG && !overlay_lock) begin
			// bit 3 has no function and stays zero
			overlay_config <= pwdata[15:0] & 16'hfff7;
		end
	end

	// separator character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			separator_char <= ARO_RST_SEP;
		end else if (apb_wr && paddr == ARO_OFS_SEP && !overlay_lock) begin
			separator_char <= pwdata[7:0];
		end
	end

	// custom string halves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			custom_string_low <= ARO_RST_CUSTOM;
			custom_string_high <= ARO_RST_CUSTOM;
		end else if (apb_wr && !overlay_lock) begin
			if (paddr == ARO_OFS_CUST_LO) begin
				custom_string_low <= pwdata;
			end
			if (paddr == ARO_OFS_CUST_HI) begin
				custom_string_high <= pwdata;
			end
		end
	end

	// lock can only be set; clearing needs a reset
	always_comb begin
		next_lock = overlay_lock;
		if (apb_wr && paddr == ARO_OFS_LOCK && pwdata[0]) begin
			next_lock = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overlay_lock <= 1'b0;
		end else begin
			overlay_lock <= next_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot latch: range and enables only change at an rf boot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_enable <= ARO_RST_ENABLE;
			boot_config <= ARO_RST_CONFIG;
		end else if (rf_boot) begin
			boot_enable <= overlay_enable;
			boot_config <= overlay_config;
		end
	end

	// decoded boot-time enables
	logic id_en, cus_en, tap_en, td_en, sep_en;
	assign id_en = boot_config[ARO_BIT_ID_EN];
	assign cus_en = boot_config[ARO_BIT_CUS_EN];
	assign tap_en = boot_config[ARO_BIT_TAP_EN];
	assign td_en = boot_config[ARO_BIT_TD_EN];
	assign sep_en = boot_config[ARO_BIT_SEP_EN];

	////////////////////////////////////////////////////////////////////////
	// overlay buffer assembly, rebuilt every cycle from live sources
	logic [7:0] overlay_buffer [0:ARO_BUF_MAX-1];
	logic [5:0] overlay_length; // bytes actually present
	always_comb begin
		logic [5:0] pos;
		pos = 6'd0;
		for (int k = 0; k < ARO_BUF_MAX; k++) begin
			overlay_buffer[k] = 8'h00;
		end
		if (id_en) begin
			for (int k = 0; k < ARO_ID_BYTES; k++) begin
				overlay_buffer[pos] = identifier_string[8*k +: 8];
				pos = pos + 6'd1;
			end
		end
		if (id_en && cus_en && sep_en) begin
			overlay_buffer[pos] = separator_char;
			pos = pos + 6'd1;
		end
		if (cus_en) begin
			for (int k = 0; k < ARO_CUS_BYTES; k++) begin
				// low word first, each word least significant byte first
				overlay_buffer[pos] = (k < ARO_BLOCK_BYTES) ?
					custom_string_low[8*(k%4) +: 8] :
					custom_string_high[8*(k%4) +: 8];
				pos = pos + 6'd1;
			end
		end
		if ((id_en || cus_en) && tap_en && sep_en) begin
			overlay_buffer[pos] = separator_char;
			pos = pos + 6'd1;
		end
		if (tap_en) begin
			for (int k = 0; k < ARO_TAP_BYTES; k++) begin
				overlay_buffer[pos] = unique_tap_code[8*k +: 8];
				pos = pos + 6'd1;
			end
		end
		if ((id_en || cus_en || tap_en) && td_en && sep_en) begin
			overlay_buffer[pos] = separator_char;
			pos = pos + 6'd1;
		end
		if (td_en) begin
			for (int k = 0; k < ARO_TD_BYTES; k++) begin
				// tamper bytes are live, a tamper event shows at once
				overlay_buffer[pos] = tamper_status[8*k +: 8];
				pos = pos + 6'd1;
			end
		end
		overlay_length = pos;
	end

	////////////////////////////////////////////////////////////////////////
	// byte range of the overlay
	logic [10:0] overlay_start_addr;
	logic [10:0] overlay_end_addr;
	logic [10:0] mem_end_addr; // last user byte
	logic [10:0] span_end; // start plus length minus one
	logic range_live; // overlay applies to reads
	assign overlay_start_addr = {1'b0, boot_config[15:ARO_BLOCK_LSB], 2'b00}
		+ {9'd0, boot_config[ARO_BLOCK_LSB-1:ARO_BYTE_LSB]};
	assign mem_end_addr = {1'b0, LAST_BLOCK, 2'b11};
	assign span_end = overlay_start_addr + {5'd0, overlay_length} - 11'd1;
	assign overlay_end_addr = (span_end < mem_end_addr) ? span_end : mem_end_addr;
	// an empty buffer would make end wrap below start, so it disables the range
	assign range_live = boot_enable && overlay_length != 6'd0;

	////////////////////////////////////////////////////////////////////////
	// read substitution, one result register per byte lane
	genvar lane;
	generate
		for (lane = 0; lane < ARO_BLOCK_BYTES; lane++) begin : g_lane
			logic [10:0] byte_addr;
			logic [10:0] buf_ofs;
			logic hit;
			assign byte_addr = {1'b0, rd_block, 2'b00} + 11'(lane);
			assign buf_ofs = byte_addr - overlay_start_addr;
			assign hit = range_live && byte_addr >= overlay_start_addr
				&& byte_addr <= overlay_end_addr;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rd_data[8*lane +: 8] <= 8'h00;
				end else if (rd_req) begin
					if (hit) begin
						rd_data[8*lane +: 8] <= overlay_buffer[buf_ofs[5:0]];
					end else begin
						rd_data[8*lane +: 8] <= um_rd_data[8*lane +: 8];
					end
				end
			end
		end
	endgenerate

	// answer strobe and untouched security status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_valid <= 1'b0;
			rd_block_security_status <= 8'h00;
		end else begin
			rd_valid <= rd_req;
			if (rd_req) begin
				rd_block_security_status <= um_block_security_status;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// block writes bypass the overlay entirely
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wr_en <= 1'b0;
			mem_wr_block <= 8'h00;
			mem_wr_data <= 32'h00000000;
		end else begin
			mem_wr_en <= wr_req;
			if (wr_req) begin
				mem_wr_block <= wr_block;
				mem_wr_data <= wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb read data mux, zero outside a read access
	always_comb begin
		prdata = 32'h00000000;
		if (apb_rd) begin
			case (paddr)
				ARO_OFS_ENABLE: prdata = {31'd0, overlay_enable};
				ARO_OFS_CONFIG: prdata = {16'd0, overlay_config};
				ARO_OFS_SEP: prdata = {24'd0, separator_char};
				ARO_OFS_CUST_LO: prdata = custom_string_low;
				ARO_OFS_CUST_HI: prdata = custom_string_high;
				ARO_OFS_LOCK: prdata = {31'd0, overlay_lock};
				ARO_OFS_BOOT: prdata = {15'd0, boot_enable, boot_config};
				ARO_OFS_RANGE: prdata = {4'd0, overlay_length[5:0], overlay_end_addr,
					overlay_start_addr};
				default: prdata = 32'h00000000;
			endcase
		end
	end
endmodule // aro_overlay

// [bench/aro_overlay_props.sv]
// port checker for the augmented read overlay
`timescale 1ns/1ps
module aro_overlay_chk #(parameter logic [7:0] LAST_BLOCK = 8'h4f) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rf_boot,
	input wire logic rd_req,
	input wire logic [31:0] um_rd_data,
	input wire logic [7:0] um_block_security_status,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic [7:0] rd_block_security_status,
	input wire logic wr_req,
	input wire logic [7:0] wr_block,
	input wire logic [31:0] wr_data,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wr_block,
	input wire logic [31:0] mem_wr_data
);
	logic booted; // no overlay may show before the first boot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) booted <= 1'b0;
		else if (rf_boot) booted <= 1'b1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence read_s; rd_req ##1 rd_valid; endsequence
	sequence acc_s; psel && penable; endsequence
	rd_answer_a: assert property (rd_req |-> read_s) else $error("read answer missing");
	rd_quiet_a: assert property (!rd_req |=> !rd_valid) else $error("stray read answer");
	rd_hold_a: assert property (!rd_req |=> $stable(rd_data)) else $error("read data moved");
	bss_pass_a: assert property (rd_req |=> rd_block_security_status == $past(um_block_security_status))
		else $error("security status altered");
	no_boot_a: assert property (!booted && rd_req |=> rd_data == $past(um_rd_data))
		else $error("overlay before boot");
	wr_pass_a: assert property (wr_req |=> mem_wr_en && mem_wr_data == $past(wr_data)
		&& mem_wr_block == $past(wr_block)) else $error("write altered");
	wr_quiet_a: assert property (!wr_req |=> !mem_wr_en) else $error("stray write");
	apb_ready_a: assert property (acc_s |-> pready) else $error("no ready");
	apb_idle_a: assert property (!(psel && penable) |-> !pslverr && prdata == 32'h0)
		else $error("apb output outside access");
endmodule // aro_overlay_chk
////////////////////////////////////////////////////////////////
bind aro_overlay aro_overlay_chk #(.LAST_BLOCK(LAST_BLOCK)) i_chk (.pclk, .presetn, .psel, .penable,
	.prdata, .pready, .pslverr, .rf_boot, .rd_req, .um_rd_data, .um_block_security_status, .rd_valid,
	.rd_data, .rd_block_security_status, .wr_req, .wr_block, .wr_data, .mem_wr_en, .mem_wr_block,
	.mem_wr_data);

// [bench/aro_reader.sv]
// reader model: block reads with memory data, single block writes
`timescale 1ns/1ps
module aro_reader (
	input wire logic pclk,
	output logic rd_req,
	output logic [7:0] rd_block,
	output logic [31:0] um_rd_data,
	output logic [7:0] um_block_security_status,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	output logic wr_req,
	output logic [7:0] wr_block,
	output logic [31:0] wr_data
);
	initial {rd_req, wr_req, rd_block, wr_block, um_rd_data, um_block_security_status, wr_data} = '0;
	// one read; memory lanes differ so a lane swap shows
	task automatic read_block(input logic [7:0] b, output logic [31:0] d);
		int n;
		@(posedge pclk);
		rd_req <= 1'b1;
		rd_block <= b;
		um_rd_data <= {4{b}} ^ 32'h03020100;
		um_block_security_status <= ~b;
		@(posedge pclk);
		rd_req <= 1'b0;
		um_rd_data <= ~um_rd_data; // stale memory must not leak through
		n = 0;
		#1;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(posedge pclk);
			#1;
			n++;
		end
		// a missing answer turns into unknown data so the compare fails
		d = (rd_valid === 1'b1) ? rd_data : 'x;
	endtask
	task automatic write_block(input logic [7:0] b, input logic [31:0] d);
		@(posedge pclk);
		wr_req <= 1'b1;
		wr_block <= b;
		wr_data <= d;
		@(posedge pclk);
		wr_req <= 1'b0;
		#1;
	endtask
endmodule // aro_reader

// [bench/tb_aro_overlay.sv]
// self-checking bench for the augmented read overlay
`timescale 1ns/1ps
module tb_aro_overlay;
	import aro_pkg::*;
	localparam logic [7:0] LB = ARO_LAST_BLOCK;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rf_boot, e, act;
	logic rd_req, rd_valid, wr_req, mem_wr_en;
	logic [7:0] paddr, rd_block, wr_block, mem_wr_block, um_block_security_status;
	logic [7:0] rd_block_security_status;
	logic [31:0] pwdata, prdata, um_rd_data, rd_data, wr_data, mem_wr_data, r;
	logic [127:0] identifier_string;
	logic [23:0] unique_tap_code, tamper_status;
	logic [15:0] ccfg; // config latched at the last boot
	logic [7:0] ob[$]; // expected overlay buffer
	int n_fail, comparisons, cs, ce;
	localparam logic [31:0] i_dut_cus_lo = 32'h64636261;
	localparam logic [31:0] i_dut_cus_hi = 32'h68676665;
	aro_overlay #(.LAST_BLOCK(LB)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rf_boot, .identifier_string, .unique_tap_code, .tamper_status,
		.rd_req, .rd_block, .um_rd_data, .um_block_security_status, .rd_valid, .rd_data,
		.rd_block_security_status, .wr_req, .wr_block, .wr_data, .mem_wr_en, .mem_wr_block, .mem_wr_data);
	aro_reader i_rdr (.pclk, .rd_req, .rd_block, .um_rd_data, .um_block_security_status, .rd_valid,
		.rd_data, .wr_req, .wr_block, .wr_data);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	// one apb transfer, held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		// a slave that never answers counts against the run
		if (pready !== 1'b1) begin
			n_fail++;
			$display("BAD apb ready expected 1 seen %b", pready);
		end
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// overlay bytes from the enables, low byte first
	task automatic build();
		logic id, cu, tp, td, sp;
		logic [63:0] cus;
		{sp, td, tp, cu, id} = {ccfg[5:4], ccfg[2:0]};
		cus = {i_dut_cus_hi, i_dut_cus_lo};
		ob = {};
		if (id) for (int i = 0; i < 16; i++) ob.push_back(identifier_string[i*8+:8]);
		if (id && cu && sp) ob.push_back(8'h2f);
		if (cu) for (int i = 0; i < 8; i++) ob.push_back(cus[i*8+:8]);
		if ((id || cu) && tp && sp) ob.push_back(8'h2f);
		if (tp) for (int i = 0; i < 3; i++) ob.push_back(unique_tap_code[i*8+:8]);
		if ((id || cu || tp) && td && sp) ob.push_back(8'h2f);
		if (td) for (int i = 0; i < 3; i++) ob.push_back(tamper_status[i*8+:8]);
	endtask
	task automatic chk_blocks();
		logic [31:0] d, x;
		int a;
		build();
		for (int b = cs / 4 - 1; b <= cs / 4 + 9 && b <= LB; b++) begin
			i_rdr.read_block(8'(b), d);
			x = {4{8'(b)}} ^ 32'h03020100;
			for (int j = 0; j < 4; j++) begin
				a = b * 4 + j;
				if (act && a >= cs && a <= ce) x[j*8+:8] = ob[a-cs];
			end
			chk("block data", x, d);
		end
	endtask
	task automatic run(input logic en, input logic [15:0] cfg);
		apb(1'b1, ARO_OFS_ENABLE, {31'h0, en});
		apb(1'b1, ARO_OFS_CONFIG, {16'h0, cfg});
		apb(1'b0, ARO_OFS_CONFIG, 32'h0);
		// bit 3 has no function and reads back zero
		chk("config", {16'h0, cfg & 16'hfff7}, r);
		@(posedge pclk) rf_boot <= 1'b1;
		@(posedge pclk) rf_boot <= 1'b0;
		{act, ccfg} = {en, cfg};
		build();
		cs = int'(cfg[15:8]) * 4 + int'(cfg[7:6]);
		ce = (cs + ob.size() - 1 < LB * 4 + 3) ? cs + ob.size() - 1 : LB * 4 + 3;
		apb(1'b0, ARO_OFS_RANGE, 32'h0);
		if (en) chk("range", {4'h0, 6'(ob.size()), 11'(ce), 11'(cs)}, r);
		chk_blocks();
		$display("config %h enable %b done", cfg, en);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#100us;
		n_fail++; // the run hung
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, rf_boot, paddr, pwdata} = '0;
		{identifier_string, unique_tap_code, tamper_status} = {128'h30313233_34353637_41424344_45464748,
			24'h393837, 24'h4e4f50};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ARO_OFS_ENABLE, 32'h0);
		chk("enable reset", 32'h0, r);
		apb(1'b0, ARO_OFS_CONFIG, 32'h0);
		chk("config reset", 32'h0020, r);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b1, ARO_OFS_SEP, 32'h2f);
		apb(1'b1, ARO_OFS_CUST_LO, i_dut_cus_lo);
		apb(1'b1, ARO_OFS_CUST_HI, i_dut_cus_hi);
		// no boot yet: memory data must pass untouched
		i_rdr.read_block(8'h2e, r);
		chk("pre boot data", {4{8'h2e}} ^ 32'h03020100, r);
		$display("reset and pre boot done");
		run(1'b0, 16'h2e77);
		run(1'b1, 16'h2e77);
		run(1'b1, 16'h0a76);
		run(1'b1, 16'h10e4);
		run(1'b1, 16'h201f);
		run(1'b1, 16'h4eb7);
		run(1'b1, 16'h3031);
		// let the new tamper value settle before the model rebuilds its buffer
		@(posedge pclk) tamper_status <= 24'h585958;
		@(posedge pclk);
		chk_blocks();
		$display("live tamper done");
		apb(1'b1, ARO_OFS_LOCK, 32'h1);
		apb(1'b1, ARO_OFS_CONFIG, 32'h0);
		chk("locked error", 32'h1, {31'h0, e});
		apb(1'b0, ARO_OFS_CONFIG, 32'h0);
		chk("locked config", 32'h3031, r);
		apb(1'b1, ARO_OFS_CUST_LO, 32'h0);
		chk("locked custom error", 32'h1, {31'h0, e});
		apb(1'b0, ARO_OFS_CUST_LO, 32'h0);
		chk("locked custom", i_dut_cus_lo, r);
		i_rdr.write_block(8'h2e, 32'hcafe0123);
		chk("write data", 32'hcafe0123, mem_wr_data);
		chk("write ctl", {23'h0, 1'b1, 8'h2e}, {23'h0, mem_wr_en, mem_wr_block});
		$display("lock and write done");
		tally_and_finish();
	end
endmodule // tb_aro_overlay
